// ==== hw/pulse_timer_map.svh ====
// register offsets, field positions, reset values and timing figures
`ifndef PULSE_TIMER_MAP_SVH
`define PULSE_TIMER_MAP_SVH

// register byte offsets
`define PT_CTRL_OFS 8'h00
`define PT_PRESET_OFS 8'h04
`define PT_COUNT_OFS 8'h08
`define PT_STATUS_OFS 8'h0C
`define PT_DATA_BASE 8'h40

// control register fields
`define PT_CTRL_POLICY_BIT 0
`define PT_CTRL_TICK_LSB 1
`define PT_CTRL_TICK_MSB 2
`define PT_CTRL_SRC_BIT 3
`define PT_CTRL_IDX_LSB 4
`define PT_CTRL_IDX_MSB 9
`define PT_CTRL_USED_MSB 9

// status register fields
`define PT_STAT_OUT_BIT 0
`define PT_STAT_RUN_BIT 1

// reset values
`define PT_CTRL_RST 10'h000
`define PT_PRESET_RST 16'h000A

// timing figures
`define PT_CLK_PERIOD_NS 25
`define PT_BASE_1S_NS 1000000000
`define PT_BASE_100MS_NS 100000000
`define PT_BASE_10MS_NS 10000000
`define PT_BASE_1MS_NS 1000000

`endif

// ==== hw/pulse_timer_pkg.sv ====
// types shared by the single-shot pulse timer
package pulse_timer_pkg;

   // what a falling trigger does to a running pulse
   typedef enum logic [0:0] {
      POLICY_INPUT = 1'b0,
      POLICY_TIME = 1'b1
   } policy_type;

   // time base of one count step
   typedef enum logic [1:0] {
      BASE_1S = 2'b00,
      BASE_100MS = 2'b01,
      BASE_10MS = 2'b10,
      BASE_1MS = 2'b11
   } tick_base_type;

   // where the pulse length comes from
   typedef enum logic [0:0] {
      SRC_CONST = 1'b0,
      SRC_DATA = 1'b1
   } length_src_type;

endpackage

// ==== hw/preset_store.sv ====
// small data register memory with two registered read ports
`timescale 1ns/1ps
`default_nettype none

module preset_store #(
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   // clock and enable
   input wire logic clk_i,
   input wire logic ce_i,
   // write port, byte lanes of a 16-bit word
   input wire logic wr_en_i,
   input wire logic [AW-1:0] wr_addr_i,
   input wire logic [1:0] wr_be_i,
   input wire logic [15:0] wr_data_i,
   // bus read port
   input wire logic [AW-1:0] rd_a_addr_i,
   output logic [15:0] rd_a_data_o,
   // pulse length read port
   input wire logic [AW-1:0] rd_b_addr_i,
   output logic [15:0] rd_b_data_o
);

   logic [15:0] mem_q [DEPTH];

   // one write process keeps the array to a single driver; lanes by enable
   always_ff @(posedge clk_i) begin
      if (ce_i && wr_en_i) begin
         for (int b = 0; b < 2; b++) begin
            if (wr_be_i[b]) begin
               mem_q[wr_addr_i][b*8 +: 8] <= wr_data_i[b*8 +: 8];
            end
         end
      end
   end

   // registered reads, so the bus sees one cycle of latency
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         rd_a_data_o <= mem_q[rd_a_addr_i];
         rd_b_data_o <= mem_q[rd_b_addr_i];
      end
   end

endmodule

`default_nettype wire

// ==== hw/single_shot_pulse_timer.sv ====
// single-shot pulse timer with classic wishbone register slave
`timescale 1ns/1ps
`default_nettype none
`include "pulse_timer_map.svh"

module single_shot_pulse_timer #(
   parameter logic [15:0] PRESET_INIT = `PT_PRESET_RST,
   parameter bit CLEAR_USED = 1'b1,
   parameter int DATA_DEPTH = 16,
   parameter int TICK_1S_CYC = `PT_BASE_1S_NS / `PT_CLK_PERIOD_NS,
   parameter int TICK_100MS_CYC = `PT_BASE_100MS_NS / `PT_CLK_PERIOD_NS,
   parameter int TICK_10MS_CYC = `PT_BASE_10MS_NS / `PT_CLK_PERIOD_NS,
   parameter int TICK_1MS_CYC = `PT_BASE_1MS_NS / `PT_CLK_PERIOD_NS
) (
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // pulse control from neighbouring logic
   input wire logic shot_trigger_i,
   input wire logic clear_i,
   // pulse and elapsed count
   output logic pulse_o,
   output logic [15:0] elapsed_o
);

   localparam int AW = $clog2(DATA_DEPTH);

   // refuse sizes the index field or divider cannot serve
   // the data window must end below the top of the 8-bit address space
   if (DATA_DEPTH < 2 || DATA_DEPTH > 32 ||
         (1 << AW) != DATA_DEPTH) begin : g_bad_depth
      $error("DATA_DEPTH must be a power of two from 2 to 32");
   end
   if (TICK_1MS_CYC < 1 || TICK_1S_CYC >= (1 << 26)) begin : g_bad_tick
      $error("tick counts must lie between 1 and 2**26-1");
   end

   logic [`PT_CTRL_USED_MSB:0] ctrl_q;
   logic [15:0] preset_q;
   logic [15:0] count_q;
   logic run_q;
   logic trig_prev_q;
   logic [25:0] div_q;
   logic pend_q;
   logic [15:0] mem_a_rd;
   logic [15:0] mem_b_rd;
   logic [31:0] rd_value;
   logic [15:0] length;
   logic [25:0] tick_limit;
   logic clr_eff;
   logic rise;
   logic fall;
   logic tick;
   logic start;
   logic mem_wr;
   logic [7:0] data_ofs;
   logic [31:0] ctrl_wr;
   logic [31:0] preset_wr;
   pulse_timer_pkg::policy_type policy;
   pulse_timer_pkg::tick_base_type base;
   pulse_timer_pkg::length_src_type src;

   // true when the address falls in the data register window
   function automatic logic in_data(input logic [7:0] adr);
      return adr >= `PT_DATA_BASE &&
         adr < 8'(`PT_DATA_BASE + 4 * DATA_DEPTH);
   endfunction

   // merge a write into a stored word lane by lane
   function automatic logic [31:0] merge(input logic [31:0] old,
         input logic [31:0] wdata, input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = wdata[b*8 +: 8];
         end
      end
      return res;
   endfunction

   assign policy = pulse_timer_pkg::policy_type'(ctrl_q[`PT_CTRL_POLICY_BIT]);
   assign base = pulse_timer_pkg::tick_base_type'(
      ctrl_q[`PT_CTRL_TICK_MSB:`PT_CTRL_TICK_LSB]);
   assign src = pulse_timer_pkg::length_src_type'(ctrl_q[`PT_CTRL_SRC_BIT]);

   // unconnected clear never acts
   assign clr_eff = CLEAR_USED ? clear_i : 1'b0;

   // edges from the sample against last cycle's sample
   assign rise = shot_trigger_i & ~trig_prev_q;
   assign fall = ~shot_trigger_i & trig_prev_q;
   assign start = rise & ~clr_eff;

   // length either the working constant or a data register
   assign length = (src == pulse_timer_pkg::SRC_DATA) ? mem_b_rd : preset_q;

   // divider limit per selected time base
   always_comb begin
      case (base)
         pulse_timer_pkg::BASE_1S: tick_limit = 26'(TICK_1S_CYC - 1);
         pulse_timer_pkg::BASE_100MS: tick_limit = 26'(TICK_100MS_CYC - 1);
         pulse_timer_pkg::BASE_10MS: tick_limit = 26'(TICK_10MS_CYC - 1);
         default: tick_limit = 26'(TICK_1MS_CYC - 1);
      endcase
   end
   assign tick = (div_q >= tick_limit);

   // trigger history, frozen with the enable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trig_prev_q <= 1'b0;
      end else if (ce_i) begin
         trig_prev_q <= shot_trigger_i;
      end
   end

   // time base divider, restarted by each trigger so the first step is whole
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_q <= 26'h0000000;
      end else if (ce_i) begin
         if (start || !run_q || tick) begin
            div_q <= 26'h0000000;
         end else begin
            div_q <= div_q + 26'h0000001;
         end
      end
   end

   // pulse state machine: clear first, then trigger, then end checks
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_q <= 1'b0;
         pulse_o <= 1'b0;
         count_q <= 16'h0000;
      end else if (ce_i) begin
         if (clr_eff) begin
            run_q <= 1'b0;
            pulse_o <= 1'b0;
         end else if (rise) begin
            count_q <= 16'h0000;
            run_q <= 1'b1;
            pulse_o <= 1'b1;
         end else if (run_q) begin
            if (length <= count_q) begin
               // reached, or length lowered to the count or below
               run_q <= 1'b0;
               pulse_o <= 1'b0;
            end else if (fall && policy == pulse_timer_pkg::POLICY_INPUT) begin
               run_q <= 1'b0;
               pulse_o <= 1'b0;
            end else if (tick) begin
               // raised length keeps counting; time priority ignores fall
               count_q <= count_q + 16'h0001;
            end
         end
         // idle: count holds its last value, never wraps
      end
   end

   assign elapsed_o = count_q;

   // bus: request taken into pend_q, answered one cycle later
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_q <= 1'b0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else if (ce_i) begin
         pend_q <= wb_cyc_i & wb_stb_i & ~pend_q & ~wb_ack_o;
         wb_ack_o <= pend_q;
         if (pend_q && !wb_we_i) begin
            wb_dat_o <= rd_value;
         end
      end
   end

   // read decode; unmapped addresses read zero
   always_comb begin
      if (wb_adr_i == `PT_CTRL_OFS) begin
         rd_value = 32'(ctrl_q);
      end else if (wb_adr_i == `PT_PRESET_OFS) begin
         rd_value = {16'h0000, preset_q};
      end else if (wb_adr_i == `PT_COUNT_OFS) begin
         rd_value = {16'h0000, count_q};
      end else if (wb_adr_i == `PT_STATUS_OFS) begin
         rd_value = {30'h00000000, run_q, pulse_o};
      end else if (in_data(wb_adr_i)) begin
         rd_value = {16'h0000, mem_a_rd};
      end else begin
         rd_value = 32'h00000000;
      end
   end

   // write data merged into the current words, lane by lane
   assign ctrl_wr = merge(32'(ctrl_q), wb_dat_i, wb_sel_i);
   assign preset_wr = merge({16'h0000, preset_q}, wb_dat_i, wb_sel_i);

   // control and working preset; reset reloads PRESET_INIT, not the value last written
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= `PT_CTRL_RST;
         preset_q <= PRESET_INIT;
      end else if (ce_i && pend_q && wb_we_i) begin
         if (wb_adr_i == `PT_CTRL_OFS) begin
            ctrl_q <= ctrl_wr[`PT_CTRL_USED_MSB:0];
         end else if (wb_adr_i == `PT_PRESET_OFS) begin
            // full 16-bit range, no clamp
            preset_q <= preset_wr[15:0];
         end
      end
   end

   assign mem_wr = pend_q & wb_we_i & in_data(wb_adr_i);

   // byte offset inside the data window, relative to its base
   assign data_ofs = wb_adr_i - `PT_DATA_BASE;

   // data registers; length port follows the index field every cycle
   preset_store #(
      .DEPTH(DATA_DEPTH),
      .AW(AW)
   ) u_store (
      .clk_i(clk_i),
      .ce_i(ce_i),
      .wr_en_i(mem_wr),
      .wr_addr_i(data_ofs[AW+1:2]),
      .wr_be_i(wb_sel_i[1:0]),
      .wr_data_i(wb_dat_i[15:0]),
      .rd_a_addr_i(data_ofs[AW+1:2]),
      .rd_a_data_o(mem_a_rd),
      .rd_b_addr_i(ctrl_q[`PT_CTRL_IDX_LSB +: AW]),
      .rd_b_data_o(mem_b_rd)
   );

   // checks on the pulse logic, register reset and bus answer
   sequence s_running_short;
      ce_i && run_q && !clr_eff && !rise && count_q < length;
   endsequence

   sequence s_bus_req;
      ce_i && wb_cyc_i && wb_stb_i && !pend_q && !wb_ack_o ##1 ce_i;
   endsequence

   a_clear_forces_low: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && clr_eff |=> !pulse_o && !run_q)
      else $error("clear did not force output low");

   a_rise_starts_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && start |=> pulse_o && run_q && count_q == 16'h0000)
      else $error("trigger rise did not start pulse");

   a_reach_ends_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && run_q && !clr_eff && !rise && count_q == length |=> !pulse_o)
      else $error("pulse did not end at length");

   a_input_prio_drop: assert property (@(posedge clk_i) disable iff (rst_i)
      s_running_short and (fall && policy == pulse_timer_pkg::POLICY_INPUT)
      |=> !pulse_o)
      else $error("input priority kept pulse after trigger fall");

   a_time_prio_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      s_running_short and (fall && policy == pulse_timer_pkg::POLICY_TIME)
      |=> pulse_o)
      else $error("time priority ended pulse early");

   a_length_lowered: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && run_q && !clr_eff && !rise && length < count_q |=> !run_q)
      else $error("lowered length did not stop pulse");

   a_raised_keeps_run: assert property (@(posedge clk_i) disable iff (rst_i)
      s_running_short and !fall |=> run_q && pulse_o)
      else $error("pulse stopped before raised length");

   a_tick_advance: assert property (@(posedge clk_i) disable iff (rst_i)
      s_running_short and tick and !fall |=> count_q == $past(count_q) + 16'h0001)
      else $error("count did not step on tick");

   a_count_holds: assert property (@(posedge clk_i) disable iff (rst_i)
      !run_q && !rise |=> $stable(count_q))
      else $error("idle count changed");

   a_edge_sample: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && shot_trigger_i |=> trig_prev_q)
      else $error("trigger history not updated");

   a_reset_reload: assert property (@(posedge clk_i)
      rst_i |=> preset_q == PRESET_INIT && policy == pulse_timer_pkg::POLICY_INPUT)
      else $error("reset did not reload preset and policy");

   a_bus_answer: assert property (@(posedge clk_i) disable iff (rst_i)
      s_bus_req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus answer not two cycles after request");

endmodule

`default_nettype wire

// ==== testbench/trigger_source.sv ====
// model of the neighbouring logic that drives trigger and clear
`timescale 1ns/1ps
`default_nettype none

module trigger_source (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // commands from the bench
   input wire logic fire_i,
   input wire logic [7:0] hold_i,
   input wire logic clr_req_i,
   // lines to the timer
   output logic shot_trigger_o,
   output logic clear_o
);
   logic [7:0] hold_q;

   // trigger stays high for hold_i cycles, then falls; clear is registered
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shot_trigger_o <= 1'b0;
         hold_q <= 8'h00;
         clear_o <= 1'b0;
      end else begin
         clear_o <= clr_req_i;
         if (fire_i) begin
            shot_trigger_o <= 1'b1;
            hold_q <= hold_i;
         end else if (hold_q > 8'h01) begin
            hold_q <= hold_q - 8'h01;
         end else begin
            shot_trigger_o <= 1'b0;
         end
      end
   end
endmodule

`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench for the single-shot pulse timer
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
   $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end

module testbench;
   logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h00000000, rdat, wb_dat_o;
   logic wb_ack_o, trig, clr, pulse_o, fire = 1'b0, clr_req = 1'b0;
   logic [7:0] hold = 8'h01;
   logic [15:0] elapsed_o, hi_cnt = 16'h0000, last_width = 16'h0000;
   logic [15:0] saved;
   int fails = 0, samples_checked = 0, len, base, i;

   // clock generation, 25 ns period
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   single_shot_pulse_timer #(.TICK_1MS_CYC(2), .TICK_10MS_CYC(3),
      .TICK_100MS_CYC(4), .TICK_1S_CYC(5)) i_single_shot_pulse_timer (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .shot_trigger_i(trig), .clear_i(clr), .pulse_o(pulse_o),
      .elapsed_o(elapsed_o));

   trigger_source i_trigger_source (.clk_i(clk_i), .rst_i(rst_i),
      .fire_i(fire), .hold_i(hold), .clr_req_i(clr_req),
      .shot_trigger_o(trig), .clear_o(clr));

   // width of the last pulse, in cycles sampled high
   always_ff @(posedge clk_i) begin
      if (pulse_o === 1'b1) begin
         hi_cnt <= hi_cnt + 16'h0001;
      end else if (hi_cnt != 16'h0000) begin
         last_width <= hi_cnt;
         hi_cnt <= 16'h0000;
      end
   end

   // cycles per count step for the shortened tick parameters
   function automatic int tick_cyc(input int b);
      return (b == 0) ? 5 : (b == 1) ? 4 : (b == 2) ? 3 : 2;
   endfunction

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // one classic cycle; request held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_i);
         if (wb_ack_o === 1'b1) break;
      end
      if (n == 50) begin
         fails++;
         conclude();
      end
      rdat = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic shot(input logic [7:0] h);
      @(posedge clk_i);
      fire <= 1'b1;
      hold <= h;
      @(posedge clk_i);
      fire <= 1'b0;
   endtask

   // wait, bounded, for the pulse to end and its width to be latched
   task automatic wait_end();
      int n;
      repeat (3) @(posedge clk_i);
      for (n = 0; n < 2000 && pulse_o !== 1'b0; n++) @(posedge clk_i);
      if (n == 2000) begin
         fails++;
         conclude();
      end
      @(posedge clk_i);
      #1;
   endtask

   initial begin
      void'($urandom(32'h5C991EF7));
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, 8'h00, 32'h0);
      `CHK(rdat[9:0], 10'h000)
      wb(1'b0, 8'h04, 32'h0);
      `CHK(rdat[15:0], 16'h000A)
      `CHK(pulse_o, 1'b0)
      $display("test reset done");
      // random bases and lengths, time priority, one-cycle trigger
      for (i = 0; i < 8; i++) begin
         base = (i < 4) ? i : $urandom % 4;
         len = (i == 0) ? 0 : $urandom % 5;
         wb(1'b1, 8'h00, 32'(1 + base * 2));
         wb(1'b1, 8'h04, 32'(len));
         shot(8'h01);
         wait_end();
         `CHK(last_width, 16'(len * tick_cyc(base) + 1))
         repeat (7) @(posedge clk_i);
         `CHK(elapsed_o, 16'(len))
      end
      $display("test random lengths done");
      // input priority: trigger falls after six cycles
      wb(1'b1, 8'h00, 32'h0);
      wb(1'b1, 8'h04, 32'h000A);
      shot(8'h06);
      wait_end();
      `CHK(last_width, 16'h0006)
      $display("test input priority done");
      // clear mid-pulse, then a rise while clear is held
      wb(1'b1, 8'h00, 32'h1);
      shot(8'h01);
      repeat (6) @(posedge clk_i);
      clr_req <= 1'b1;
      repeat (3) @(posedge clk_i);
      #1;
      `CHK(pulse_o, 1'b0)
      shot(8'h01);
      repeat (5) @(posedge clk_i);
      #1;
      `CHK(pulse_o, 1'b0)
      clr_req <= 1'b0;
      $display("test clear done");
      // length raised while running
      wb(1'b1, 8'h04, 32'h2);
      shot(8'h01);
      wb(1'b1, 8'h04, 32'h6);
      wait_end();
      `CHK(last_width, 16'd31)
      // length lowered below the count while running
      wb(1'b1, 8'h04, 32'h14);
      shot(8'h01);
      repeat (30) @(posedge clk_i);
      wb(1'b1, 8'h04, 32'h2);
      repeat (2) @(posedge clk_i);
      #1;
      `CHK(pulse_o, 1'b0)
      saved = elapsed_o;
      repeat (12) @(posedge clk_i);
      `CHK(elapsed_o, saved)
      $display("test length change done");
      // data register source, index 3, 1 ms base
      wb(1'b1, 8'h4C, 32'hABCD0003);
      wb(1'b1, 8'h00, 32'h3F);
      shot(8'h01);
      wait_end();
      `CHK(last_width, 16'h0007)
      wb(1'b0, 8'h20, 32'h0);
      `CHK(rdat, 32'h00000000)
      wb(1'b0, 8'h4C, 32'h0);
      `CHK(rdat, 32'h00000003)
      wb(1'b0, 8'h08, 32'h0);
      `CHK(rdat, 32'h00000003)
      wb(1'b1, 8'h04, 32'hFFFF);
      wb(1'b0, 8'h04, 32'h0);
      `CHK(rdat[15:0], 16'hFFFF)
      $display("test data source done");
      // enable low for ten cycles stretches a running pulse by ten
      wb(1'b1, 8'h00, 32'h1);
      wb(1'b1, 8'h04, 32'h3);
      shot(8'h01);
      repeat (4) @(posedge clk_i);
      ce_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      ce_i <= 1'b1;
      wait_end();
      `CHK(last_width, 16'd26)
      $display("test enable freeze done");
      // reset reloads the PRESET_INIT length, not the one written over the bus
      @(posedge clk_i);
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, 8'h04, 32'h0);
      `CHK(rdat[15:0], 16'h000A)
      $display("test reload done");
      conclude();
   end
endmodule

`default_nettype wire
